// ==== shared/mfo_defines.svh ====
// Purpose: Offsets, reset values, codes and timing for the output selector
// Assumes: 32-bit Avalon-MM slave with byte addresses
// Notes:   Included by bare name
`ifndef MFO_DEFINES_SVH
`define MFO_DEFINES_SVH

// Register byte offsets
`define MFO_OFS_DUAL_MODE     6'h00
`define MFO_OFS_OC_SEL        6'h04
`define MFO_OFS_RELAY_SEL     6'h08
`define MFO_OFS_DUAL_SEL      6'h0C
`define MFO_OFS_PULSE_PERIOD  6'h10
`define MFO_OFS_SET_COUNT     6'h14
`define MFO_OFS_SPEC_COUNT    6'h18
`define MFO_OFS_TARGET_LEN    6'h1C
`define MFO_OFS_RUN_THRESHOLD 6'h20
`define MFO_OFS_OUT_STATUS    6'h24

// Reset values
`define MFO_RST_DUAL_MODE     1'h0
`define MFO_RST_OC_SEL        6'h00
`define MFO_RST_RELAY_SEL     6'h02
`define MFO_RST_DUAL_SEL      6'h00
`define MFO_RST_PULSE_PERIOD  16'h03E8
`define MFO_RST_WORD          16'h0000

// Field limits
`define MFO_MODE_MAX          16'h0001
`define MFO_CODE_MAX          16'h0026

// Function codes
`define MFO_FN_NONE           6'h00
`define MFO_FN_RUNNING        6'h01
`define MFO_FN_FAULT          6'h02
`define MFO_FN_ZERO_SPEED     6'h05
`define MFO_FN_MOTOR_PREALARM 6'h06
`define MFO_FN_DRIVE_PREALARM 6'h07
`define MFO_FN_SET_COUNT      6'h08
`define MFO_FN_SPEC_COUNT     6'h09
`define MFO_FN_LENGTH         6'h0A
`define MFO_FN_SEQ_DONE       6'h0B
`define MFO_FN_RUN_TIME       6'h0C
`define MFO_FN_FREQ_LIMITED   6'h0D
`define MFO_FN_TORQUE_LIMIT   6'h0E
`define MFO_FN_READY          6'h0F
`define MFO_FN_AI_COMPARE     6'h10
`define MFO_FN_AT_UPPER       6'h11
`define MFO_FN_AT_LOWER       6'h12
`define MFO_FN_UNDERVOLTAGE   6'h13
`define MFO_FN_REVERSE        6'h21

// Timing
`define MFO_CLK_HZ            100000000
`define MFO_PULSE_MAX_HZ      100000
`define MFO_PULSE_MIN_CYCLES  ((`MFO_CLK_HZ + `MFO_PULSE_MAX_HZ - 1) / `MFO_PULSE_MAX_HZ)
`define MFO_SEQ_PULSE_MS      250
`define MFO_SEQ_PULSE_CYCLES  ((`MFO_CLK_HZ / 1000) * `MFO_SEQ_PULSE_MS)
`define MFO_PREWARN_MS        16'h2710

`endif

// ==== shared/mfo_pkg.sv ====
// Purpose: Types for the output selector
// Assumes: Nothing beyond the defines header
// Notes:   No constants live here
package mfo_pkg;

	typedef enum logic [1:0] {
		MFO_BUS_IDLE = 2'b01,
		MFO_BUS_ACK  = 2'b10
	} mfo_bus_e;

	// Drive conditions from the control core
	typedef struct packed {
		logic        running;
		logic        fault;
		logic        freq_zero;
		logic        motor_prealarm;
		logic        drive_ovl_active;
		logic [15:0] drive_ovl_trip_ms;
		logic [15:0] count;
		logic [15:0] length;
		logic        seq_cycle_done;
		logic [15:0] run_time;
		logic        set_beyond_upper;
		logic        set_beyond_lower;
		logic        at_upper;
		logic        at_lower;
		logic        speed_mode;
		logic        torque_limited;
		logic        supplies_stable;
		logic [15:0] analog_input_first;
		logic [15:0] analog_input_second;
		logic        undervoltage;
		logic        reverse;
	} mfo_status_s;

	typedef struct packed {
		mfo_bus_e    bus;
		logic [31:0] rdata;
		logic        dual_mode;
		logic [5:0]  oc_sel;
		logic [5:0]  relay_sel;
		logic [5:0]  dual_sel;
		logic [15:0] pulse_period;
		logic [15:0] set_count;
		logic [15:0] spec_count;
		logic [15:0] target_len;
		logic [15:0] run_thr;
		logic [15:0] pulse_cnt;
		logic        pulse_lvl;
		logic [31:0] seq_cnt;
	} mfo_state_s;

endpackage

// ==== hdl/mfo_output_select.sv ====
// Purpose: Routes drive conditions to the open-collector, relay and dual terminal
// Assumes: Status inputs come from logic on sys_clk
// Notes:   Dual mode 0 is pulse output, 1 is switch output
`timescale 1ns/100ps
`include "mfo_defines.svh"

module mfo_output_select #(
	parameter int unsigned SEQ_PULSE_CYCLES = `MFO_SEQ_PULSE_CYCLES
) (
	// Clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 sys_rst,
	// Avalon-MM slave
	input  wire logic [5:0]           avs_address,
	input  wire logic                 avs_read,
	input  wire logic                 avs_write,
	input  wire logic [31:0]          avs_writedata,
	input  wire logic [3:0]           avs_byteenable,
	output logic      [31:0]          avs_readdata,
	output logic                      avs_waitrequest,
	// Drive conditions
	input  wire mfo_pkg::mfo_status_s status,
	// Output terminals, high means ON
	output logic                      oc_out,
	output logic                      relay_output,
	output logic                      dual_out
);

	localparam logic [15:0] PULSE_MIN = 16'(`MFO_PULSE_MIN_CYCLES);
	localparam logic [31:0] SEQ_LEN   = 32'(SEQ_PULSE_CYCLES);

	mfo_pkg::mfo_state_s st;
	mfo_pkg::mfo_state_s next_st;

	logic        seq_pulse;
	logic [15:0] half_period;
	logic        accept;

	// Byte-lane merge into a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
		merge16 = old;
		if (be[0]) begin
			merge16[7:0] = wd[7:0];
		end
		if (be[1]) begin
			merge16[15:8] = wd[15:8];
		end
	endfunction

	// Condition chosen by one function code
	function automatic logic select_fn(input logic [5:0] code, input mfo_pkg::mfo_status_s s,
	                                   input logic seq_on, input mfo_pkg::mfo_state_s r);
		case (code)
			`MFO_FN_NONE:           select_fn = 1'b0;
			`MFO_FN_RUNNING:        select_fn = s.running;
			`MFO_FN_FAULT:          select_fn = s.fault;
			`MFO_FN_ZERO_SPEED:     select_fn = s.running & s.freq_zero;
			`MFO_FN_MOTOR_PREALARM: select_fn = s.motor_prealarm;
			`MFO_FN_DRIVE_PREALARM: select_fn = s.drive_ovl_active &
			                                    (s.drive_ovl_trip_ms <= `MFO_PREWARN_MS);
			`MFO_FN_SET_COUNT:      select_fn = s.count >= r.set_count;
			`MFO_FN_SPEC_COUNT:     select_fn = s.count >= r.spec_count;
			`MFO_FN_LENGTH:         select_fn = s.length > r.target_len;
			`MFO_FN_SEQ_DONE:       select_fn = seq_on;
			`MFO_FN_RUN_TIME:       select_fn = s.run_time > r.run_thr;
			`MFO_FN_FREQ_LIMITED:   select_fn = (s.set_beyond_upper & s.at_upper) |
			                                    (s.set_beyond_lower & s.at_lower);
			`MFO_FN_TORQUE_LIMIT:   select_fn = s.speed_mode & s.torque_limited;
			`MFO_FN_READY:          select_fn = s.supplies_stable & ~s.fault & s.running;
			`MFO_FN_AI_COMPARE:     select_fn = s.analog_input_first > s.analog_input_second;
			`MFO_FN_AT_UPPER:       select_fn = s.at_upper;
			`MFO_FN_AT_LOWER:       select_fn = s.running & s.at_lower;
			`MFO_FN_UNDERVOLTAGE:   select_fn = s.undervoltage;
			`MFO_FN_REVERSE:        select_fn = s.running & s.reverse;
			default:                select_fn = 1'b0;
		endcase
	endfunction

	// Code write accepted only inside range
	function automatic logic code_ok(input logic [15:0] v);
		code_ok = v <= `MFO_CODE_MAX;
	endfunction

	assign seq_pulse       = st.seq_cnt != 32'h0000_0000;
	assign accept          = (st.bus == mfo_pkg::MFO_BUS_ACK) && (avs_read || avs_write);
	assign avs_waitrequest = (avs_read || avs_write) && (st.bus != mfo_pkg::MFO_BUS_ACK);
	assign avs_readdata    = st.rdata;

	// Clamp period so frequency stays at or below the ceiling
	assign half_period = ((st.pulse_period < PULSE_MIN) ? PULSE_MIN : st.pulse_period) >> 1;

	// Outputs follow selector and condition directly, dual terminal only in switch mode
	assign oc_out       = select_fn(st.oc_sel, status, seq_pulse, st);
	assign relay_output = select_fn(st.relay_sel, status, seq_pulse, st);
	assign dual_out     = st.dual_mode ? select_fn(st.dual_sel, status, seq_pulse, st) : st.pulse_lvl;

	always_comb begin
		logic [15:0] wv;
		wv      = 16'h0000;
		next_st = st;

		// Bus handshake: one wait cycle, read data loaded before accept
		case (st.bus)
			mfo_pkg::MFO_BUS_IDLE: begin
				if (avs_read || avs_write) begin
					next_st.bus = mfo_pkg::MFO_BUS_ACK;
					case (avs_address)
						`MFO_OFS_DUAL_MODE:     next_st.rdata = {31'h0000_0000, st.dual_mode};
						`MFO_OFS_OC_SEL:        next_st.rdata = {26'h000_0000, st.oc_sel};
						`MFO_OFS_RELAY_SEL:     next_st.rdata = {26'h000_0000, st.relay_sel};
						`MFO_OFS_DUAL_SEL:      next_st.rdata = {26'h000_0000, st.dual_sel};
						`MFO_OFS_PULSE_PERIOD:  next_st.rdata = {16'h0000, st.pulse_period};
						`MFO_OFS_SET_COUNT:     next_st.rdata = {16'h0000, st.set_count};
						`MFO_OFS_SPEC_COUNT:    next_st.rdata = {16'h0000, st.spec_count};
						`MFO_OFS_TARGET_LEN:    next_st.rdata = {16'h0000, st.target_len};
						`MFO_OFS_RUN_THRESHOLD: next_st.rdata = {16'h0000, st.run_thr};
						`MFO_OFS_OUT_STATUS:    next_st.rdata = {28'h000_0000, seq_pulse, dual_out,
						                                         relay_output, oc_out};
						default:                next_st.rdata = 32'h0000_0000;
					endcase
				end
			end
			mfo_pkg::MFO_BUS_ACK: begin
				next_st.bus = mfo_pkg::MFO_BUS_IDLE;
				if (avs_write) begin
					case (avs_address)
						`MFO_OFS_DUAL_MODE: begin
							wv = merge16({15'h0000, st.dual_mode}, avs_writedata, avs_byteenable);
							if (wv <= `MFO_MODE_MAX) begin
								next_st.dual_mode = wv[0];
							end
						end
						`MFO_OFS_OC_SEL: begin
							wv = merge16({10'h000, st.oc_sel}, avs_writedata, avs_byteenable);
							if (code_ok(wv)) begin
								next_st.oc_sel = wv[5:0];
							end
						end
						`MFO_OFS_RELAY_SEL: begin
							wv = merge16({10'h000, st.relay_sel}, avs_writedata, avs_byteenable);
							if (code_ok(wv)) begin
								next_st.relay_sel = wv[5:0];
							end
						end
						`MFO_OFS_DUAL_SEL: begin
							wv = merge16({10'h000, st.dual_sel}, avs_writedata, avs_byteenable);
							if (code_ok(wv)) begin
								next_st.dual_sel = wv[5:0];
							end
						end
						`MFO_OFS_PULSE_PERIOD:  next_st.pulse_period = merge16(st.pulse_period, avs_writedata,
						                                                       avs_byteenable);
						`MFO_OFS_SET_COUNT:     next_st.set_count = merge16(st.set_count, avs_writedata, avs_byteenable);
						`MFO_OFS_SPEC_COUNT:    next_st.spec_count = merge16(st.spec_count, avs_writedata,
						                                                     avs_byteenable);
						`MFO_OFS_TARGET_LEN:    next_st.target_len = merge16(st.target_len, avs_writedata,
						                                                     avs_byteenable);
						`MFO_OFS_RUN_THRESHOLD: next_st.run_thr = merge16(st.run_thr, avs_writedata, avs_byteenable);
						default:                next_st.rdata = st.rdata;
					endcase
				end
			end
			default: next_st.bus = mfo_pkg::MFO_BUS_IDLE;
		endcase

		// Pulse output generator
		if (st.pulse_cnt + 16'h0001 >= half_period) begin
			next_st.pulse_cnt = 16'h0000;
			next_st.pulse_lvl = ~st.pulse_lvl;
		end else begin
			next_st.pulse_cnt = st.pulse_cnt + 16'h0001;
		end

		// Sequence cycle pulse, retriggered by each completion
		if (status.seq_cycle_done) begin
			next_st.seq_cnt = SEQ_LEN;
		end else if (st.seq_cnt != 32'h0000_0000) begin
			next_st.seq_cnt = st.seq_cnt - 32'h0000_0001;
		end

		if (sys_rst) begin
			next_st.bus          = mfo_pkg::MFO_BUS_IDLE;
			next_st.rdata        = 32'h0000_0000;
			next_st.dual_mode    = `MFO_RST_DUAL_MODE;
			next_st.oc_sel       = `MFO_RST_OC_SEL;
			next_st.relay_sel    = `MFO_RST_RELAY_SEL;
			next_st.dual_sel     = `MFO_RST_DUAL_SEL;
			next_st.pulse_period = `MFO_RST_PULSE_PERIOD;
			next_st.set_count    = `MFO_RST_WORD;
			next_st.spec_count   = `MFO_RST_WORD;
			next_st.target_len   = `MFO_RST_WORD;
			next_st.run_thr      = `MFO_RST_WORD;
			next_st.pulse_cnt    = 16'h0000;
			next_st.pulse_lvl    = 1'b0;
			next_st.seq_cnt      = 32'h0000_0000;
		end
	end

	always_ff @(posedge sys_clk) begin
		st <= next_st;
	end

	// Helper: cycles the pulse level has held
	localparam int HALF_MIN = 499;
	logic        lvl_q;
	logic [15:0] lvl_age;
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			lvl_q   <= 1'b0;
			lvl_age <= 16'hFFFF;
		end else begin
			lvl_q   <= st.pulse_lvl;
			lvl_age <= (st.pulse_lvl != lvl_q) ? 16'h0001 : ((lvl_age == 16'hFFFF) ? lvl_age : lvl_age + 16'h0001);
		end
	end

	property p_dual_mode;
		@(posedge sys_clk) disable iff (sys_rst)
		!st.dual_mode |-> (dual_out == st.pulse_lvl);
	endproperty
	a_dual_mode: assert property (p_dual_mode) else $error("dual terminal not on pulse in pulse mode");

	property p_pulse_rate;
		@(posedge sys_clk) disable iff (sys_rst)
		(st.pulse_lvl != lvl_q) |-> (lvl_age >= HALF_MIN);
	endproperty
	a_pulse_rate: assert property (p_pulse_rate) else $error("pulse half period too short");

	property p_oc_range;
		@(posedge sys_clk) disable iff (sys_rst)
		(accept && avs_write && avs_address == `MFO_OFS_OC_SEL && avs_byteenable[0] &&
		 avs_writedata[7:0] > 8'h26) |=> $stable(st.oc_sel);
	endproperty
	a_oc_range: assert property (p_oc_range) else $error("out of range code stored");

	property p_relay_reset;
		@(posedge sys_clk)
		$past(sys_rst) && !sys_rst |-> (st.relay_sel == 6'h02) && (st.oc_sel == 6'h00) && !st.dual_mode;
	endproperty
	a_relay_reset: assert property (p_relay_reset) else $error("selector reset value wrong");

	property p_code_none;
		@(posedge sys_clk) disable iff (sys_rst)
		(st.oc_sel == 6'h00) |-> !oc_out;
	endproperty
	a_code_none: assert property (p_code_none) else $error("code 0 drove output");

	property p_fault;
		@(posedge sys_clk) disable iff (sys_rst)
		(st.relay_sel == 6'h02) |-> (relay_output == status.fault);
	endproperty
	a_fault: assert property (p_fault) else $error("relay not following fault");

	property p_zero_speed;
		@(posedge sys_clk) disable iff (sys_rst)
		(st.oc_sel == 6'h05) |-> (oc_out == (status.running && status.freq_zero));
	endproperty
	a_zero_speed: assert property (p_zero_speed) else $error("zero speed output wrong");

	property p_seq_pulse;
		@(posedge sys_clk) disable iff (sys_rst)
		(status.seq_cycle_done && st.relay_sel == 6'h0B) ##1 (st.relay_sel == 6'h0B)[*8] |-> relay_output;
	endproperty
	a_seq_pulse: assert property (p_seq_pulse) else $error("sequence pulse ended early");

	property p_seq_len;
		@(posedge sys_clk) disable iff (sys_rst)
		st.seq_cnt <= SEQ_LEN;
	endproperty
	a_seq_len: assert property (p_seq_len) else $error("sequence pulse too long");

	property p_lower_stop;
		@(posedge sys_clk) disable iff (sys_rst)
		(st.relay_sel == 6'h12 && !status.running) |-> !relay_output;
	endproperty
	a_lower_stop: assert property (p_lower_stop) else $error("lower limit on while stopped");

	property p_reserved;
		@(posedge sys_clk) disable iff (sys_rst)
		(st.oc_sel == 6'h15 || st.oc_sel == 6'h03) |-> !oc_out;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved code drove output");

	property p_running;
		@(posedge sys_clk) disable iff (sys_rst)
		(st.oc_sel == `MFO_FN_RUNNING) |-> (oc_out == status.running);
	endproperty
	a_running: assert property (p_running) else $error("running output wrong");

	property p_motor_prealarm;
		@(posedge sys_clk) disable iff (sys_rst)
		(st.relay_sel == `MFO_FN_MOTOR_PREALARM) |-> (relay_output == status.motor_prealarm);
	endproperty
	a_motor_prealarm: assert property (p_motor_prealarm) else $error("motor pre-alarm output wrong");

	property p_drive_prealarm;
		@(posedge sys_clk) disable iff (sys_rst)
		(st.oc_sel == `MFO_FN_DRIVE_PREALARM) |->
		(oc_out == (status.drive_ovl_active && status.drive_ovl_trip_ms <= `MFO_PREWARN_MS));
	endproperty
	a_drive_prealarm: assert property (p_drive_prealarm) else $error("drive pre-alarm output wrong");

	property p_set_count;
		@(posedge sys_clk) disable iff (sys_rst)
		(st.oc_sel == `MFO_FN_SET_COUNT) |-> (oc_out == (status.count >= st.set_count));
	endproperty
	a_set_count: assert property (p_set_count) else $error("set count output wrong");

	property p_spec_count;
		@(posedge sys_clk) disable iff (sys_rst)
		(st.relay_sel == `MFO_FN_SPEC_COUNT) |-> (relay_output == (status.count >= st.spec_count));
	endproperty
	a_spec_count: assert property (p_spec_count) else $error("specified count output wrong");

	property p_length;
		@(posedge sys_clk) disable iff (sys_rst)
		(st.oc_sel == `MFO_FN_LENGTH) |-> (oc_out == (status.length > st.target_len));
	endproperty
	a_length: assert property (p_length) else $error("length output wrong");

	property p_run_time;
		@(posedge sys_clk) disable iff (sys_rst)
		(st.relay_sel == `MFO_FN_RUN_TIME) |-> (relay_output == (status.run_time > st.run_thr));
	endproperty
	a_run_time: assert property (p_run_time) else $error("running time output wrong");

	property p_freq_limited;
		@(posedge sys_clk) disable iff (sys_rst)
		(st.oc_sel == `MFO_FN_FREQ_LIMITED && !status.at_upper && !status.at_lower) |-> !oc_out;
	endproperty
	a_freq_limited: assert property (p_freq_limited) else $error("limit output on off limit");

	property p_torque;
		@(posedge sys_clk) disable iff (sys_rst)
		(st.relay_sel == `MFO_FN_TORQUE_LIMIT) |-> (relay_output == (status.speed_mode && status.torque_limited));
	endproperty
	a_torque: assert property (p_torque) else $error("torque limit output wrong");

	property p_ready;
		@(posedge sys_clk) disable iff (sys_rst)
		(st.oc_sel == `MFO_FN_READY && status.fault) |-> !oc_out;
	endproperty
	a_ready: assert property (p_ready) else $error("ready output on with fault");

	property p_ai_compare;
		@(posedge sys_clk) disable iff (sys_rst)
		(st.relay_sel == `MFO_FN_AI_COMPARE) |->
		(relay_output == (status.analog_input_first > status.analog_input_second));
	endproperty
	a_ai_compare: assert property (p_ai_compare) else $error("analog compare output wrong");

	property p_at_upper;
		@(posedge sys_clk) disable iff (sys_rst)
		(st.oc_sel == `MFO_FN_AT_UPPER) |-> (oc_out == status.at_upper);
	endproperty
	a_at_upper: assert property (p_at_upper) else $error("upper limit output wrong");

	property p_undervoltage;
		@(posedge sys_clk) disable iff (sys_rst)
		(st.relay_sel == `MFO_FN_UNDERVOLTAGE) |-> (relay_output == status.undervoltage);
	endproperty
	a_undervoltage: assert property (p_undervoltage) else $error("undervoltage output wrong");

	property p_reverse;
		@(posedge sys_clk) disable iff (sys_rst)
		(st.oc_sel == `MFO_FN_REVERSE && !status.running) |-> !oc_out;
	endproperty
	a_reverse: assert property (p_reverse) else $error("reverse output on while stopped");

	property p_dual_switch;
		@(posedge sys_clk) disable iff (sys_rst)
		(st.dual_mode && st.dual_sel == st.oc_sel) |-> (dual_out == oc_out);
	endproperty
	a_dual_switch: assert property (p_dual_switch) else $error("dual terminal not on switch code");

	c_fault_relay: cover property (@(posedge sys_clk) disable iff (sys_rst) relay_output && st.relay_sel == 6'h02);
	c_pulse_toggle: cover property (@(posedge sys_clk) disable iff (sys_rst) !st.dual_mode && $rose(dual_out));
	c_bus_write: cover property (@(posedge sys_clk) disable iff (sys_rst) accept && avs_write);
	c_switch_mode: cover property (@(posedge sys_clk) disable iff (sys_rst) st.dual_mode && dual_out);
	c_seq_pulse: cover property (@(posedge sys_clk) disable iff (sys_rst) relay_output && st.relay_sel == 6'h0B);

endmodule

// ==== sim/mfo_load_model.sv ====
// Purpose: External load on the output terminals
// Assumes: Loads sample the terminals on sys_clk
// Notes:   Measures pulse period and high time, counts relay on-cycles
`timescale 1ns/100ps

module mfo_load_model (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	// Terminals
	input  wire logic        oc_out,
	input  wire logic        relay_output,
	input  wire logic        dual_out,
	// Measurements
	output logic      [31:0] last_period,
	output logic      [31:0] last_high,
	output logic      [31:0] relay_on
);
	logic        prev;
	logic [31:0] run_len;

	// Period from rise to rise, high time from rise to fall
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			prev <= 1'b0;
			run_len <= 32'h0;
			last_period <= 32'h0;
			last_high <= 32'h0;
			relay_on <= 32'h0;
		end else begin
			prev <= dual_out;
			run_len <= run_len + 32'h1;
			if (dual_out && !prev) begin
				last_period <= run_len;
				run_len <= 32'h1;
			end
			if (!dual_out && prev) begin
				last_high <= run_len;
			end
			if (relay_output) begin
				relay_on <= relay_on + 32'h1;
			end
		end
	end
endmodule

// ==== sim/test_multifunction_output_select.sv ====
// Purpose: Self-checking bench for the output selector
// Assumes: One wait cycle per bus access, outputs combinational
// Notes:   Short sequence pulse of 20 cycles
`timescale 1ns/100ps
`include "mfo_defines.svh"

module test_multifunction_output_select;
	localparam int unsigned SEQ   = 20;
	localparam int          LIMIT = 30000;
	localparam logic [15:0] SETC  = 16'h0010;
	localparam logic [15:0] SPEC  = 16'h0011;
	localparam logic [15:0] TGT   = 16'h0030;
	localparam logic [15:0] THR   = 16'h0040;

	logic                 sys_clk;
	logic                 sys_rst;
	logic [5:0]           avs_address;
	logic                 avs_read;
	logic                 avs_write;
	logic [31:0]          avs_writedata;
	logic [3:0]           avs_byteenable;
	logic [31:0]          avs_readdata;
	logic                 avs_waitrequest;
	mfo_pkg::mfo_status_s status;
	logic                 oc_out;
	logic                 relay_output;
	logic                 dual_out;
	logic [31:0]          last_period;
	logic [31:0]          last_high;
	logic [31:0]          relay_on;
	logic [31:0]          rd;
	logic [31:0]          base;
	logic [5:0]           codes [22];
	logic [5:0]           rst_ofs [9];
	logic [31:0]          rst_val [9];
	int                   mismatches;
	int                   checked;
	int                   cycles = 0;

	mfo_output_select #(.SEQ_PULSE_CYCLES(SEQ)) mfo_output_select_i (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .status(status),
		.oc_out(oc_out), .relay_output(relay_output), .dual_out(dual_out)
	);

	mfo_load_model mfo_load_model_i (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .oc_out(oc_out), .relay_output(relay_output),
		.dual_out(dual_out), .last_period(last_period), .last_high(last_high), .relay_on(relay_on)
	);

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic end_of_test();
		if (mismatches == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			mismatches++;
			end_of_test();
		end
	end

	task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic cmp_bit(input string what, input logic exp, input logic got);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s expected %b seen %b", what, exp, got);
		end
	endtask

	// Called just after a rising edge; holds the request until accepted
	task automatic bus_write(input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_write <= 1'b1;
		@(posedge sys_clk iff !avs_waitrequest);
		avs_write <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic bus_read(input logic [5:0] a, output logic [31:0] d);
		avs_address <= a;
		avs_read <= 1'b1;
		@(posedge sys_clk iff !avs_waitrequest);
		d = avs_readdata;
		avs_read <= 1'b0;
		@(posedge sys_clk);
	endtask

	// Output expected for a code under given conditions
	function automatic logic exp_out(input logic [5:0] c, input mfo_pkg::mfo_status_s s);
		case (c)
			6'h01: return s.running;
			6'h02: return s.fault;
			6'h05: return s.running & s.freq_zero;
			6'h06: return s.motor_prealarm;
			6'h07: return s.drive_ovl_active & (s.drive_ovl_trip_ms <= 16'h2710);
			6'h08: return s.count >= SETC;
			6'h09: return s.count >= SPEC;
			6'h0A: return s.length > TGT;
			6'h0C: return s.run_time > THR;
			6'h0D: return (s.set_beyond_upper & s.at_upper) | (s.set_beyond_lower & s.at_lower);
			6'h0E: return s.speed_mode & s.torque_limited;
			6'h0F: return s.supplies_stable & !s.fault & s.running;
			6'h10: return s.analog_input_first > s.analog_input_second;
			6'h11: return s.at_upper;
			6'h12: return s.at_lower & s.running;
			6'h13: return s.undervoltage;
			6'h21: return s.reverse & s.running;
			default: return 1'b0;
		endcase
	endfunction

	// Condition pattern spanning each threshold boundary
	function automatic mfo_pkg::mfo_status_s mk_status(input logic [3:0] i);
		mfo_pkg::mfo_status_s s;
		s = '0;
		s.running = i[0];
		s.fault = i[1];
		s.freq_zero = i[2];
		s.motor_prealarm = i[3];
		s.drive_ovl_active = i[0] ^ i[3];
		s.drive_ovl_trip_ms = 16'h270F + {14'h0, i[2:1]};
		s.count = 16'h000F + {14'h0, i[1:0]};
		s.length = 16'h002F + {14'h0, i[2:1]};
		s.run_time = 16'h003F + {14'h0, i[1:0]};
		s.set_beyond_upper = i[1];
		s.set_beyond_lower = i[2];
		s.at_upper = i[3];
		s.at_lower = i[2] | i[3];
		s.speed_mode = i[2];
		s.torque_limited = i[3];
		s.supplies_stable = i[2] | i[3];
		s.analog_input_first = 16'h0005 + {14'h0, i[1:0]};
		s.analog_input_second = 16'h0006;
		s.undervoltage = i[1] ^ i[2];
		s.reverse = i[3];
		return s;
	endfunction

	initial begin
		codes = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h09, 6'h0A,
			6'h0C, 6'h0D, 6'h0E, 6'h0F, 6'h10, 6'h11, 6'h12, 6'h13, 6'h14, 6'h21, 6'h26};
		rst_ofs = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h14, 6'h18, 6'h1C, 6'h20};
		rst_val = '{32'h0, 32'h0, 32'h2, 32'h0, 32'h3E8, 32'h0, 32'h0, 32'h0, 32'h0};
		sys_rst = 1'b1;
		avs_address = 6'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hF;
		status = '0;
		mismatches = 0;
		checked = 0;
		repeat (20) @(posedge sys_clk);
		sys_rst <= 1'b0;
		status.fault <= 1'b1;
		@(posedge sys_clk);
		cmp_bit("relay default fault", 1'b1, relay_output);
		for (int n = 0; n < 9; n++) begin
			bus_read(rst_ofs[n], rd);
			cmp_word("reset value", rst_val[n], rd);
		end
		// Pulse mode: period clamped at the 100 kHz ceiling
		bus_write(`MFO_OFS_PULSE_PERIOD, 32'h0000_000A, 4'hF);
		repeat (2500) @(posedge sys_clk);
		cmp_word("pulse period", 32'd1000, last_period);
		cmp_word("pulse high", 32'd500, last_high);
		bus_write(`MFO_OFS_PULSE_PERIOD, 32'h0000_07D0, 4'hF);
		repeat (5000) @(posedge sys_clk);
		cmp_word("pulse period long", 32'd2000, last_period);
		// Switch mode and thresholds
		bus_write(`MFO_OFS_DUAL_MODE, 32'h1, 4'hF);
		bus_write(`MFO_OFS_SET_COUNT, {16'h0, SETC}, 4'hF);
		bus_write(`MFO_OFS_SPEC_COUNT, {16'h0, SPEC}, 4'hF);
		bus_write(`MFO_OFS_TARGET_LEN, {16'h0, TGT}, 4'hF);
		bus_write(`MFO_OFS_RUN_THRESHOLD, {16'h0, THR}, 4'hF);
		for (int k = 0; k < 22; k++) begin
			bus_write(`MFO_OFS_OC_SEL, {26'h0, codes[k]}, 4'hF);
			bus_write(`MFO_OFS_RELAY_SEL, {26'h0, codes[k]}, 4'hF);
			bus_write(`MFO_OFS_DUAL_SEL, {26'h0, codes[k]}, 4'hF);
			for (int i = 0; i < 16; i++) begin
				status <= mk_status(i[3:0]);
				@(negedge sys_clk);
				cmp_bit("oc_out", exp_out(codes[k], mk_status(i[3:0])), oc_out);
				cmp_bit("relay_output", exp_out(codes[k], mk_status(i[3:0])), relay_output);
				cmp_bit("dual_out", exp_out(codes[k], mk_status(i[3:0])), dual_out);
				@(posedge sys_clk);
			end
		end
		// Sequence cycle pulse on the relay, status word while active
		bus_write(`MFO_OFS_RELAY_SEL, 32'h0000_000B, 4'hF);
		base = relay_on;
		status <= '0;
		@(posedge sys_clk);
		status.seq_cycle_done <= 1'b1;
		@(posedge sys_clk);
		status.seq_cycle_done <= 1'b0;
		bus_read(`MFO_OFS_OUT_STATUS, rd);
		cmp_word("status word", 32'h0000_000A, rd);
		repeat (40) @(posedge sys_clk);
		cmp_word("sequence pulse cycles", SEQ, relay_on - base);
		// Refused and partial writes
		bus_write(`MFO_OFS_OC_SEL, 32'h0000_0027, 4'hF);
		bus_read(`MFO_OFS_OC_SEL, rd);
		cmp_word("code above range", 32'h26, rd);
		bus_write(`MFO_OFS_OC_SEL, 32'h0000_FF05, 4'h1);
		bus_read(`MFO_OFS_OC_SEL, rd);
		cmp_word("lane0 write", 32'h05, rd);
		bus_write(`MFO_OFS_DUAL_MODE, 32'h0000_0002, 4'hF);
		bus_read(`MFO_OFS_DUAL_MODE, rd);
		cmp_word("mode above range", 32'h1, rd);
		bus_write(6'h28, 32'hFFFF_FFFF, 4'hF);
		bus_read(6'h28, rd);
		cmp_word("unmapped read", 32'h0, rd);
		// Reset in mid-run restores the defaults
		sys_rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		bus_read(`MFO_OFS_RELAY_SEL, rd);
		cmp_word("relay code after reset", 32'h2, rd);
		bus_read(`MFO_OFS_DUAL_MODE, rd);
		cmp_word("dual mode after reset", 32'h0, rd);
		end_of_test();
	end
endmodule
